// File: inc/ebpc_if.sv
// interface: external port pins between the device and an alternate master
interface ebpc_if;
  import ebpc_pkg::*;
  logic [ADDR_W-1:0] addr_o;
  logic              addr_oe;
  logic [DATA_W-1:0] data_o;
  logic              data_oe;
  logic [DATA_W-1:0] data_i;
  logic              program_space_select_n;
  logic              data_space_select_n;
  logic              xy_select;
  logic              rd_n;
  logic              wr_n;
  logic              strobe_oe;
  logic              bus_select_strobe_n;
  logic              bus_grant_out_n;
  logic              bus_needed_out_n;
  logic              bus_request_in_n;
  logic              bus_wait_in_n;
  modport device (
    output addr_o, addr_oe, data_o, data_oe, program_space_select_n,
           data_space_select_n, xy_select, rd_n, wr_n, strobe_oe,
           bus_select_strobe_n, bus_grant_out_n, bus_needed_out_n,
    input  data_i, bus_request_in_n, bus_wait_in_n
  );
  modport master (
    input  bus_grant_out_n, bus_needed_out_n, bus_select_strobe_n,
    output bus_request_in_n, bus_wait_in_n
  );
endinterface : ebpc_if

// File: inc/ebpc_pkg.sv
// package: constants and types for the external bus port control block
package ebpc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 24;
  // space codes of a core access request
  typedef enum logic [1:0] {
    EBPC_SP_PROG = 2'h0,
    EBPC_SP_X    = 2'h1,
    EBPC_SP_Y    = 2'h2,
    EBPC_SP_VEC  = 2'h3
  } ebpc_space_t;
  // device end states, one-hot
  typedef enum logic [4:0] {
    EBPC_IDLE  = 5'h01,
    EBPC_SETUP = 5'h02,
    EBPC_XFER  = 5'h04,
    EBPC_DRAIN = 5'h08,
    EBPC_REL   = 5'h10
  } ebpc_state_t;
  // master end states, one-hot
  typedef enum logic [3:0] {
    EBPC_M_IDLE = 4'h1,
    EBPC_M_REQ  = 4'h2,
    EBPC_M_OWN  = 4'h4,
    EBPC_M_DONE = 4'h8
  } ebpc_mstate_t;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;
  localparam int SETUP_CYC = 1;
endpackage : ebpc_pkg

// File: logic/ebpc_device.sv
// device end: external port sequencing, strobes and bus handover
// Function
// - y access drives xy select low
// - development mode vector fetch drives xy low
// - strobes float in reset or grant
// - bus select asserted ahead of access
// - bus select plus wait makes waits
// - bus select held high, not floated
// - request: finish instruction, then float bus
// - internal execution continues while bus released
// - request deasserted: device drives bus
// - grant output tells master it owns bus
// - grant held deasserted high in reset
// - bus needed asserted when bus required
// - bus needed deasserted when not required
// - needed while not master means stalled
// - bus needed is no early notice
// - wait input lengthens cycle as needed
// - write strobe low during writes
// - read strobe low during reads
// - board pulls request and wait high
// - program and data selects per space
// - address holds last value when idle
module ebpc_device
  import ebpc_pkg::*;
(
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_dev_mode,
  input  wire logic                        i_acc_valid,
  output logic                             o_acc_ready,
  input  wire logic                        i_acc_write,
  input  wire ebpc_pkg::ebpc_space_t       i_acc_space,
  input  wire logic [ebpc_pkg::ADDR_W-1:0] i_acc_addr,
  input  wire logic [ebpc_pkg::DATA_W-1:0] i_acc_wdata,
  output logic      [ebpc_pkg::DATA_W-1:0] o_acc_rdata,
  output logic                             o_acc_done,
  input  wire logic                        i_insn_end,
  input  wire logic                        i_need_bus,
  output logic                             o_stalled,
  ebpc_if.device                           port
);
  import ebpc_pkg::*;

  ebpc_state_t       state_ff, nxt_state;
  logic [1:0]        req_sync_ff, wait_sync_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff;
  logic              write_ff, done_ff;
  ebpc_space_t       space_ff;
  logic              req_on, wait_on;

  // two-stage synchronisers for the request and wait pin inputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      req_sync_ff  <= 2'h0;
      wait_sync_ff <= 2'h0;
    end else begin
      req_sync_ff  <= {req_sync_ff[0], ~port.bus_request_in_n};
      wait_sync_ff <= {wait_sync_ff[0], ~port.bus_wait_in_n};
    end
  end
  assign req_on  = req_sync_ff[1];
  assign wait_on = wait_sync_ff[1];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EBPC_IDLE: begin
        if (req_on && i_insn_end) nxt_state = EBPC_REL;
        else if (i_acc_valid) nxt_state = EBPC_SETUP;
      end
      EBPC_SETUP: nxt_state = EBPC_XFER;
      EBPC_XFER: begin
        if (!wait_on) nxt_state = EBPC_DRAIN;
      end
      EBPC_DRAIN: nxt_state = EBPC_IDLE;
      EBPC_REL: begin
        if (!req_on) nxt_state = EBPC_IDLE;
      end
      default: nxt_state = EBPC_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) state_ff <= EBPC_IDLE;
    else       state_ff <= nxt_state;
  end

  // capture the access; address holds otherwise
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      addr_ff  <= ADDR_RST;
      wdata_ff <= DATA_RST;
      write_ff <= 1'b0;
      space_ff <= EBPC_SP_PROG;
    end else if (state_ff == EBPC_IDLE && nxt_state == EBPC_SETUP) begin
      addr_ff  <= i_acc_addr;
      wdata_ff <= i_acc_wdata;
      write_ff <= i_acc_write;
      space_ff <= i_acc_space;
    end
  end

  // read data captured when the wait is released
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_ff <= DATA_RST;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= (state_ff == EBPC_XFER) && !wait_on;
      if (state_ff == EBPC_XFER && !wait_on && !write_ff) rdata_ff <= port.data_i;
    end
  end

  logic active, released;
  assign active   = (state_ff == EBPC_SETUP) || (state_ff == EBPC_XFER);
  assign released = (state_ff == EBPC_REL);

  assign o_acc_ready = (state_ff == EBPC_IDLE) && !(req_on && i_insn_end);
  assign o_acc_rdata = rdata_ff;
  assign o_acc_done  = done_ff;
  assign o_stalled   = released && i_need_bus;

  assign port.addr_o  = addr_ff;
  assign port.addr_oe = !i_rst && !released;
  assign port.data_o  = wdata_ff;
  assign port.data_oe = !i_rst && !released && active && write_ff;
  assign port.strobe_oe = !i_rst && !released;
  assign port.program_space_select_n = !(active && space_ff == EBPC_SP_PROG);
  assign port.data_space_select_n =
    !(active && (space_ff == EBPC_SP_X || space_ff == EBPC_SP_Y));
  assign port.xy_select = !((space_ff == EBPC_SP_Y) ||
                            (space_ff == EBPC_SP_VEC && i_dev_mode));
  assign port.rd_n = !(state_ff == EBPC_XFER && !write_ff);
  assign port.wr_n = !(state_ff == EBPC_XFER && write_ff);
  assign port.bus_select_strobe_n = i_rst || released || !active;
  assign port.bus_grant_out_n = i_rst || !released;
  assign port.bus_needed_out_n = !(i_need_bus || active);
endmodule : ebpc_device

// File: logic/ebpc_master.sv
// master end: requests the external bus and inserts wait states
module ebpc_master
  import ebpc_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_want_bus,
  input  wire logic i_wait_req,
  output logic      o_owner,
  output logic      o_dev_needs_bus,
  ebpc_if.master    port
);
  import ebpc_pkg::*;

  ebpc_mstate_t state_ff, nxt_state;
  logic [1:0]   grant_sync_ff, need_sync_ff;
  logic         req_ff, wait_ff, owner_ff;
  logic         granted, needed;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      grant_sync_ff <= 2'h0;
      need_sync_ff  <= 2'h0;
    end else begin
      grant_sync_ff <= {grant_sync_ff[0], ~port.bus_grant_out_n};
      need_sync_ff  <= {need_sync_ff[0], ~port.bus_needed_out_n};
    end
  end
  assign granted = grant_sync_ff[1];
  assign needed  = need_sync_ff[1];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EBPC_M_IDLE: if (i_want_bus) nxt_state = EBPC_M_REQ;
      EBPC_M_REQ:  if (granted) nxt_state = EBPC_M_OWN;
      // give bus back when done or when the device stalls for it
      EBPC_M_OWN:  if (!i_want_bus || needed) nxt_state = EBPC_M_DONE;
      EBPC_M_DONE: if (!granted) nxt_state = EBPC_M_IDLE;
      default:     nxt_state = EBPC_M_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) state_ff <= EBPC_M_IDLE;
    else       state_ff <= nxt_state;
  end

  // request and wait pins idle high from reset; owner low
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      req_ff   <= 1'b0;
      wait_ff  <= 1'b0;
      owner_ff <= 1'b0;
    end else begin
      req_ff   <= (nxt_state == EBPC_M_REQ) || (nxt_state == EBPC_M_OWN);
      // raised ahead of bus select: the device sees wait two clocks late
      wait_ff  <= i_wait_req;
      owner_ff <= (nxt_state == EBPC_M_OWN);
    end
  end

  assign port.bus_request_in_n = !req_ff;
  assign port.bus_wait_in_n    = !wait_ff;
  assign o_owner         = owner_ff;
  assign o_dev_needs_bus = needed;
endmodule : ebpc_master

// File: tb/ebpc_sva.sv
// checker: port-level timing of the external bus port
module ebpc_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic strobe_oe,
  input wire logic addr_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bus_select_strobe_n,
  input wire logic bus_grant_out_n,
  input wire logic bus_request_in_n,
  input wire logic bus_wait_in_n
);
  wire act = !rd_n || !wr_n;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_setup; $fell(bus_select_strobe_n) && rd_n && wr_n; endsequence
  sequence s_xfer; rd_n != wr_n; endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    i_rst |-> !strobe_oe && bus_select_strobe_n && bus_grant_out_n) else $error("not quiet");
  a_grant_floats: assert property (
    !bus_grant_out_n |-> !strobe_oe && !addr_oe && bus_select_strobe_n) else $error("float");
  a_grant_on_req: assert property (
    $fell(bus_grant_out_n) |-> !bus_request_in_n) else $error("unrequested grant");
  a_grant_return: assert property (
    $rose(bus_request_in_n) |-> ##[1:3] bus_grant_out_n) else $error("bus not taken back");
  a_owner_drives: assert property (
    !bus_select_strobe_n |-> strobe_oe && addr_oe) else $error("access not driven");
  a_select_leads: assert property (
    s_setup |=> s_xfer) else $error("select not ahead of strobe");
  a_wait_holds: assert property (
    !bus_wait_in_n [*3] ##0 act |=> act) else $error("wait ignored");
  a_strobe_ends: assert property (
    bus_wait_in_n [*3] ##0 act |=> !act) else $error("strobe overstays");
endmodule : ebpc_sva

// File: tb/testbench.sv
// testbench: device and master ends joined by one interface
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ebpc_pkg::*;
  logic              clk, rst, mode, vld, rdy, wr, done, iend, need, stl, want, wreq, own, dn;
  ebpc_space_t       sp;
  logic [ADDR_W-1:0] ad;
  logic [DATA_W-1:0] wd, rdat, dq, wq;
  int                bad_count, check_count;
  ebpc_if bus();
  assign bus.data_i = dq;
  ebpc_device i_ebpc_device (.i_ref_clk(clk), .i_rst(rst), .i_dev_mode(mode),
    .i_acc_valid(vld), .o_acc_ready(rdy), .i_acc_write(wr), .i_acc_space(sp),
    .i_acc_addr(ad), .i_acc_wdata(wd), .o_acc_rdata(rdat), .o_acc_done(done),
    .i_insn_end(iend), .i_need_bus(need), .o_stalled(stl), .port(bus.device));
  ebpc_master i_ebpc_master (.i_ref_clk(clk), .i_rst(rst), .i_want_bus(want),
    .i_wait_req(wreq), .o_owner(own), .o_dev_needs_bus(dn), .port(bus.master));
  ebpc_sva u_sva (.i_ref_clk(clk), .i_rst(rst), .strobe_oe(bus.strobe_oe),
    .addr_oe(bus.addr_oe), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .bus_select_strobe_n(bus.bus_select_strobe_n), .bus_grant_out_n(bus.bus_grant_out_n),
    .bus_request_in_n(bus.bus_request_in_n), .bus_wait_in_n(bus.bus_wait_in_n));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %0h got %0h", n, e, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // one access; hold 0 means no wait, else the wait request drops at loop step hold, hold+1 clocks after valid
  task automatic acc(input logic w, input ebpc_space_t s, input int hold);
    int t, xf;
    logic xy, ds;
    xf = 0;
    wq = '0;
    wr = w;
    sp = s;
    ad = ad + 16'h0123;
    wd = {ad, 8'hA5};
    dq = ~wd;
    wreq = hold > 0;
    for (t = 0; t < 30 && rdy !== 1'b1; t++) @(negedge clk);
    vld = 1;
    for (t = 0; t < 30 && done !== 1'b1; t++) begin
      @(negedge clk);
      vld = 0;
      if (t == hold) wreq = 0;
      if (!bus.bus_select_strobe_n) {xy, ds} = {bus.xy_select, bus.data_space_select_n};
      if (!(w ? bus.wr_n : bus.rd_n)) xf++;
      if (!bus.wr_n && bus.data_oe) wq = bus.data_o;
    end
    if (t == 30) begin
      chk("done", 1, done);
      end_of_test();
    end
    chk("xy", !(s == EBPC_SP_Y || (s == EBPC_SP_VEC && mode)), xy);
    if (s != EBPC_SP_VEC) chk("ds", s == EBPC_SP_PROG, ds);
    if (!w) chk("rdata", dq, rdat);
    if (w) chk("wdata", wd, wq);
    chk("xfer", 1, hold ? xf > 1 : xf == 1);
    chk("addr", ad, bus.addr_o);
    dq = ~dq;
  endtask : acc
  task automatic wait_gnt(input logic v);
    int t;
    for (t = 0; bus.bus_grant_out_n !== v; t++) begin
      if (t == 20) begin
        chk("gnt_wait", v, bus.bus_grant_out_n);
        end_of_test();
      end
      @(negedge clk);
    end
  endtask : wait_gnt
  task automatic t_spaces;
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      for (int k = 0; k < 8; k++) acc(k[0], ebpc_space_t'(k[2:1]), 0);
    end
  endtask : t_spaces
  task automatic t_waits;
    acc(0, EBPC_SP_X, 6);
    acc(1, EBPC_SP_Y, 6);
  endtask : t_waits
  task automatic t_handover;
    iend = 0;
    want = 1;
    need = 1;
    repeat (6) @(negedge clk);
    chk("held", 1, bus.bus_grant_out_n);
    chk("needed", 0, bus.bus_needed_out_n);
    iend = 1;
    wait_gnt(0);
    need = 0;
    repeat (3) @(negedge clk);
    chk("float", 0, {bus.strobe_oe, bus.addr_oe, bus.data_oe});
    chk("bs_rel", 1, bus.bus_select_strobe_n);
    chk("refuse", 0, rdy);
    chk("idle_need", 1, bus.bus_needed_out_n);
    need = 1;
    @(negedge clk);
    chk("stall", 3, {stl, own});
    @(negedge clk);
    chk("dev_needs", 1, dn);
    want = 0;
    need = 0;
    wait_gnt(1);
    acc(0, EBPC_SP_PROG, 0);
  endtask : t_handover
  task automatic t_reset_grant;
    want = 1;
    wait_gnt(0);
    rst = 1;
    want = 0;
    repeat (2) @(negedge clk);
    chk("rst_gnt", 3, {bus.bus_grant_out_n, bus.bus_select_strobe_n});
    chk("rst_oe", 0, {bus.strobe_oe, bus.addr_oe, bus.data_oe});
    rst = 0;
    @(negedge clk);
    acc(1, EBPC_SP_X, 0);
  endtask : t_reset_grant
  initial begin
    rst = 1;
    {mode, vld, wr, iend, need, want, wreq} = 7'h00;
    ad = '0;
    wd = '0;
    dq = '0;
    sp = EBPC_SP_PROG;
    repeat (4) @(negedge clk);
    chk("rst_oe", 0, {bus.strobe_oe, bus.addr_oe, bus.data_oe});
    chk("rst_bs", 3, {bus.bus_select_strobe_n, bus.bus_grant_out_n});
    rst = 0;
    @(negedge clk);
    t_spaces();
    t_waits();
    t_handover();
    t_reset_grant();
    end_of_test();
  end
endmodule : testbench
